// file: hdl/cfgbk_defs.svh
// constants for the configuration bank slice: indices, reset values, field positions
// assumes an 8-bit index/data configuration port in front of it
`ifndef CFGBK_DEFS_SVH
`define CFGBK_DEFS_SVH
`define CFGBK_IDX_BASE_LO     8'h12
`define CFGBK_IDX_BASE_HI     8'h13
`define CFGBK_IDX_RATE_SH     8'h14
`define CFGBK_IDX_SER1_SH     8'h15
`define CFGBK_IDX_SER2_SH     8'h16
`define CFGBK_IDX_OVERRIDE    8'h17
`define CFGBK_IDX_RSV_FIRST   8'h18
`define CFGBK_IDX_RSV_LAST    8'h1d
`define CFGBK_IDX_GAME_BASE   8'h1e
`define CFGBK_IDX_DRV_TYPE    8'h1f
`define CFGBK_RST_BASE_LO_S0  8'hf0
`define CFGBK_RST_BASE_LO_S1  8'h70
`define CFGBK_RST_BASE_HI     8'h03
`define CFGBK_RST_OVERRIDE    8'h03
`define CFGBK_RST_GAME_BASE   8'h80
`define CFGBK_RST_DRV_TYPE    8'h00
`define CFGBK_RST_SHADOW      8'h00
`define CFGBK_BASE_HI_MASK    8'h07
`define CFGBK_BASE_LO_MASK    8'hfe
`define CFGBK_OVR_MASK        8'h07
`define CFGBK_OVR_DC0_BIT     0
`define CFGBK_OVR_DC1_BIT     1
`define CFGBK_OVR_WP_BIT      2
`define CFGBK_PINFN_GAME_BIT  0
`define CFGBK_GAME_NIB_ONE    4'h1
`endif

// file: hdl/cfgbk_pkg.sv
// types for the configuration bank slice
// assumes cfgbk_defs.svh holds all numeric constants
`default_nettype none
package cfgbk_pkg;
  // floppy controller signals toward drive pins
  typedef struct packed {
    logic step_pulse_n;
    logic drive_select0_n;
    logic drive_select1_n;
    logic density_select;
    logic rate_bit0;
    logic rate_bit1;
  } cfgbk_fdc_type;
  // game_chip_select decode modes
  typedef enum logic [1:0] {
    CFGBK_GAME_OFF  = 2'b00,
    CFGBK_GAME_ONE  = 2'b01,
    CFGBK_GAME_EIGHT = 2'b10,
    CFGBK_GAME_ALL  = 2'b11
  } cfgbk_game_mode_type;
endpackage
`default_nettype wire

// file: hdl/cfgbk_regs.sv
// configuration register slice: port base relocation, shadows, drive overrides,
// game chip select decode and drive type mapping.
// assumes an index/data front end supplies config state, index and data strobes.
// Operation
// - low base holds A7..A1, A0 zero
// - high base holds A10..A8 only
// - strap picks base reset value
// - decode base changes on high write
// - access only in config state, indexed
// - index 14h shadows rate select
// - index 15h shadows serial1 fifo control
// - index 16h shadows serial2 fifo control
// - override register resets to 03h
// - disk change override set only
// - step with select clears override
// - disk changed bit combined expression
// - write protect forced when selected
// - overrides act on both floppy paths
// - indices 18h-1dh read zero, ignore writes
// - game base resets 80h, A9..A4
// - game mode bits choose decode
// - game select needs cs low, A10 zero
// - pin function bit overrides game select
// - drive type map resets zero
// - type maps density/rate outputs
`timescale 1ns/10ps
`default_nettype none
`include "cfgbk_defs.svh"
module cfgbk_regs
  import cfgbk_pkg::*;
(
  input  wire logic          clk_sys_in,        // 25 MHz system clock
  input  wire logic          sys_rst_in,        // sync reset, active high
  input  wire logic          base_strap_pin_in, // strap picks power-up base
  input  wire logic          cfg_state_in,      // device in configuration state
  input  wire logic [7:0]    config_index_reg_in, // current configuration index
  input  wire logic          cfg_wr_in,         // data port write strobe
  input  wire logic          cfg_rd_in,         // data port read strobe
  input  wire logic [7:0]    cfg_wdata_in,      // data port write data
  output logic      [7:0]    cfg_rdata_out,     // data port read data
  output logic      [10:0]   cfg_port_base_out, // active config port base
  input  wire logic          rate_wr_in,        // fdc rate-select write strobe
  input  wire logic          ser1_fcr_wr_in,    // serial1 fifo control write
  input  wire logic          ser2_fcr_wr_in,    // serial2 fifo control write
  input  wire logic [7:0]    run_wdata_in,      // run-time write data
  input  wire cfgbk_fdc_type fdc_in,            // controller drive signals
  input  wire logic          disk_changed_n_in, // disk change pin, active high term
  input  wire logic          write_protect_n_in,    // write protect pin, active low
  input  wire logic          pp_write_protect_n_in, // wp via parallel port, active low
  output logic               dir_disk_changed_out, // digital input bit 7
  output logic               fdc_write_protect_n_out, // internal wp, active low
  input  wire logic [15:0]   io_addr_in,        // host address
  input  wire logic          chip_select_n_in,  // host chip select, active low
  input  wire logic          pin_function_register_in, // pin function bit 0
  input  wire logic          power_good_input_in, // power good pin
  output logic               game_chip_select_out,  // shared game/pg pin level
  output logic               drive_density_out0_out, // drive density 0
  output logic               drive_density_out1_out  // drive density 1
);

  logic [7:0]  base_lo_r;
  logic [7:0]  base_lo_nxt;
  logic [2:0]  base_hi_r;
  logic [2:0]  base_hi_nxt;
  logic [10:0] port_base_r;
  logic [10:0] port_base_nxt;
  logic [7:0]  rate_sh_r;
  logic [7:0]  ser1_sh_r;
  logic [7:0]  ser2_sh_r;
  logic [2:0]  ovr_r;
  logic [2:0]  ovr_nxt;
  logic [7:0]  game_r;
  logic [7:0]  dtype_r;
  logic        rst_seen_r;  // high in the cycle after a reset edge

  wire acc_wr = cfg_state_in & cfg_wr_in;
  wire wr_lo  = acc_wr & (config_index_reg_in == `CFGBK_IDX_BASE_LO);
  wire wr_hi  = acc_wr & (config_index_reg_in == `CFGBK_IDX_BASE_HI);
  wire wr_ovr = acc_wr & (config_index_reg_in == `CFGBK_IDX_OVERRIDE);
  wire wr_gm  = acc_wr & (config_index_reg_in == `CFGBK_IDX_GAME_BASE);
  wire wr_dt  = acc_wr & (config_index_reg_in == `CFGBK_IDX_DRV_TYPE);

  // drive selects and step as active-high terms
  wire sel0 = ~fdc_in.drive_select0_n;
  wire sel1 = ~fdc_in.drive_select1_n;
  wire step = ~fdc_in.step_pulse_n;

  // strap reset value
  // strap base value
  wire [7:0] lo_rst = base_strap_pin_in ? `CFGBK_RST_BASE_LO_S1 : `CFGBK_RST_BASE_LO_S0;
  // reset images, cut to the register widths below
  wire [7:0] hi_rst  = `CFGBK_RST_BASE_HI;
  wire [7:0] ovr_rst = `CFGBK_RST_OVERRIDE;

  assign base_lo_nxt = wr_lo ? (cfg_wdata_in & `CFGBK_BASE_LO_MASK) : base_lo_r;
  assign base_hi_nxt = wr_hi ? cfg_wdata_in[2:0] : base_hi_r;
  // decode moves on high write; relies on ordering by software
  assign port_base_nxt = wr_hi ? {cfg_wdata_in[2:0], base_lo_r[7:1], 1'b0} : port_base_r;

  // disk change overrides: set by write of 1, cleared by step while selected; set wins; wp bit follows writes
  // write one sets only
  assign ovr_nxt[`CFGBK_OVR_DC0_BIT] = (wr_ovr & cfg_wdata_in[`CFGBK_OVR_DC0_BIT])
                                       | (ovr_r[`CFGBK_OVR_DC0_BIT] & ~(step & sel0));
  assign ovr_nxt[`CFGBK_OVR_DC1_BIT] = (wr_ovr & cfg_wdata_in[`CFGBK_OVR_DC1_BIT])
                                       | (ovr_r[`CFGBK_OVR_DC1_BIT] & ~(step & sel1));
  assign ovr_nxt[`CFGBK_OVR_WP_BIT]  = wr_ovr ? cfg_wdata_in[`CFGBK_OVR_WP_BIT]
                                              : ovr_r[`CFGBK_OVR_WP_BIT];

  // strap is sampled by the clock while reset is held, not asynchronously
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      base_lo_r   <= lo_rst;
      base_hi_r   <= hi_rst[2:0];
      port_base_r <= {hi_rst[2:0], lo_rst};
      ovr_r       <= ovr_rst[2:0];
      game_r      <= `CFGBK_RST_GAME_BASE;
      dtype_r     <= `CFGBK_RST_DRV_TYPE;
      rst_seen_r  <= 1'b1;
    end else begin
      base_lo_r   <= base_lo_nxt;
      base_hi_r   <= base_hi_nxt;
      port_base_r <= port_base_nxt;
      ovr_r       <= ovr_nxt;
      if (wr_gm) begin
        game_r <= cfg_wdata_in;
      end
      if (wr_dt) begin
        dtype_r <= cfg_wdata_in;
      end
      rst_seen_r  <= 1'b0;
    end
  end

  // shadow copies of write-only run-time registers
  // shadow capture
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rate_sh_r <= `CFGBK_RST_SHADOW;
      ser1_sh_r <= `CFGBK_RST_SHADOW;
      ser2_sh_r <= `CFGBK_RST_SHADOW;
    end else begin
      if (rate_wr_in) begin
        rate_sh_r <= run_wdata_in;
      end
      if (ser1_fcr_wr_in) begin
        ser1_sh_r <= run_wdata_in;
      end
      if (ser2_fcr_wr_in) begin
        ser2_sh_r <= run_wdata_in;
      end
    end
  end

  // read mux; reserved and unknown indices read zero
  // reserved reads zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    case (config_index_reg_in)
      `CFGBK_IDX_BASE_LO:   rd_mux = base_lo_r;
      `CFGBK_IDX_BASE_HI:   rd_mux = {5'h00, base_hi_r};
      `CFGBK_IDX_RATE_SH:   rd_mux = rate_sh_r;
      `CFGBK_IDX_SER1_SH:   rd_mux = ser1_sh_r;
      `CFGBK_IDX_SER2_SH:   rd_mux = ser2_sh_r;
      `CFGBK_IDX_OVERRIDE:  rd_mux = {5'h00, ovr_r};
      `CFGBK_IDX_GAME_BASE: rd_mux = game_r;
      `CFGBK_IDX_DRV_TYPE:  rd_mux = dtype_r;
      default:              rd_mux = 8'h00;
    endcase
  end
  assign cfg_rdata_out     = (cfg_state_in & cfg_rd_in) ? rd_mux : 8'h00;
  assign cfg_port_base_out = port_base_r;

  // status overrides; one path feeds both pin sets
  // disk change expression
  assign dir_disk_changed_out = (sel0 & ovr_r[`CFGBK_OVR_DC0_BIT])
                              | (sel1 & ovr_r[`CFGBK_OVR_DC1_BIT]) | disk_changed_n_in;
  assign fdc_write_protect_n_out = write_protect_n_in & pp_write_protect_n_in
                                 & ~(ovr_r[`CFGBK_OVR_WP_BIT] & (sel0 | sel1));

  // game chip select decode
  cfgbk_game_mode_type gmode;
  assign gmode = cfgbk_game_mode_type'(game_r[1:0]);
  wire hi_match = (io_addr_in[9:4] == game_r[7:2]);
  logic nib_ok;
  always_comb begin
    case (gmode)
      CFGBK_GAME_OFF:   nib_ok = 1'b0;
      CFGBK_GAME_ONE:   nib_ok = (io_addr_in[3:0] == `CFGBK_GAME_NIB_ONE);
      CFGBK_GAME_EIGHT: nib_ok = ~io_addr_in[3];
      CFGBK_GAME_ALL:   nib_ok = 1'b1;
      default:          nib_ok = 1'b0;
    endcase
  end
  wire game_hit = hi_match & nib_ok & ~chip_select_n_in & ~io_addr_in[10];
  assign game_chip_select_out = pin_function_register_in ? power_good_input_in : game_hit;

  // drive type of selected drive; odd bit is type bit 0
  // selected drive type
  wire [1:0] dsel = sel1 ? 2'd1 : 2'd0;
  wire       tb0  = dtype_r[{dsel, 1'b1}];
  wire       tb1  = dtype_r[{dsel, 1'b0}];
  logic den0;
  logic den1;
  always_comb begin
    case ({tb0, tb1})
      2'b00: begin
        den0 = fdc_in.density_select;
        den1 = fdc_in.rate_bit0;
      end
      2'b01: begin
        den0 = fdc_in.rate_bit1;
        den1 = fdc_in.rate_bit0;
      end
      2'b10: begin
        den0 = ~fdc_in.density_select;
        den1 = fdc_in.rate_bit0;
      end
      default: begin
        den0 = fdc_in.rate_bit0;
        den1 = fdc_in.rate_bit1;
      end
    endcase
  end
  assign drive_density_out0_out = den0;
  assign drive_density_out1_out = den1;

  // checks
  low_base_even_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    base_lo_r[0] == 1'b0) else $error("low base bit0 set");
  hi_only_moves_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_lo && !wr_hi) |=> $stable(port_base_r)) else $error("base moved on low write");
  hi_write_moves_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wr_hi |=> port_base_r == {$past(cfg_wdata_in[2:0]), base_lo_r[7:1], 1'b0})
    else $error("base not updated on high write");
  strap_reset_a: assert property (@(posedge clk_sys_in)
    sys_rst_in |=> base_lo_r == ($past(base_strap_pin_in) ? `CFGBK_RST_BASE_LO_S1 : `CFGBK_RST_BASE_LO_S0))
    else $error("bad strap reset");
  ovr_reset_a: assert property (@(posedge clk_sys_in)
    sys_rst_in |=> ovr_r == ovr_rst[2:0]) else $error("override reset wrong");
  dc_sticky_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (ovr_r[0] && !(step && sel0)) |=> ovr_r[0]) else $error("override lost");
  dc_clear_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (step && sel1 && !(wr_ovr && cfg_wdata_in[1])) |=> !ovr_r[1]) else $error("override not cleared");
  dir_bit_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (sel0 && ovr_r[0]) |-> dir_disk_changed_out) else $error("disk change not forced");
  wp_force_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (ovr_r[2] && sel0) |-> !fdc_write_protect_n_out) else $error("wp not forced");
  rsv_zero_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (config_index_reg_in >= 8'h18 && config_index_reg_in <= 8'h1d) |-> cfg_rdata_out == 8'h00)
    else $error("reserved index nonzero");
  game_qual_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!pin_function_register_in && (chip_select_n_in || io_addr_in[10])) |-> !game_chip_select_out)
    else $error("game select unqualified");
  no_cfg_rd_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !cfg_state_in |-> cfg_rdata_out == 8'h00) else $error("read outside config state");

  // reset images, checked in the cycle after a reset edge
  hi_reset_a: assert property (@(posedge clk_sys_in)
    rst_seen_r |-> {5'h00, base_hi_r} == `CFGBK_RST_BASE_HI)
    else $error("high base reset wrong");

  game_reset_a: assert property (@(posedge clk_sys_in)
    rst_seen_r |-> game_r == `CFGBK_RST_GAME_BASE)
    else $error("game base reset wrong");

  type_reset_a: assert property (@(posedge clk_sys_in)
    rst_seen_r |-> dtype_r == `CFGBK_RST_DRV_TYPE)
    else $error("drive type reset wrong");

  shadow_reset_a: assert property (@(posedge clk_sys_in)
    rst_seen_r |-> rate_sh_r == `CFGBK_RST_SHADOW)
    else $error("rate shadow reset wrong");

  // accepted writes land one edge later
  lo_write_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wr_lo |=> base_lo_r == {$past(cfg_wdata_in[7:1]), 1'b0})
    else $error("low base write lost");

  hi_write_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wr_hi |=> base_hi_r == $past(cfg_wdata_in[2:0]))
    else $error("high base write lost");

  game_write_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wr_gm |=> game_r == $past(cfg_wdata_in))
    else $error("game base write lost");

  type_write_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wr_dt |=> dtype_r == $past(cfg_wdata_in))
    else $error("drive type write lost");

  wp_write_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    wr_ovr |=> ovr_r[2] == $past(cfg_wdata_in[2]))
    else $error("write protect bit not stored");

  // shadows follow run-time strobes only
  rate_shadow_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    rate_wr_in |=> rate_sh_r == $past(run_wdata_in))
    else $error("rate shadow not captured");

  ser1_shadow_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ser1_fcr_wr_in |=> ser1_sh_r == $past(run_wdata_in))
    else $error("serial1 shadow not captured");

  ser2_shadow_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ser2_fcr_wr_in |=> ser2_sh_r == $past(run_wdata_in))
    else $error("serial2 shadow not captured");

  shadow_ro_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (acc_wr && !rate_wr_in) |=> $stable(rate_sh_r))
    else $error("config write reached rate shadow");

  // override set and clear paths
  dc0_clear_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (step && sel0 && !(wr_ovr && cfg_wdata_in[0])) |=> !ovr_r[0])
    else $error("drive0 override not cleared");

  dc1_sticky_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (ovr_r[1] && !(step && sel1)) |=> ovr_r[1])
    else $error("drive1 override lost");

  dc_set_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (wr_ovr && cfg_wdata_in[0]) |=> ovr_r[0])
    else $error("drive0 override not set");

  // status bits seen by the controller
  dir_bit1_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (sel1 && ovr_r[1]) |-> dir_disk_changed_out)
    else $error("drive1 change not forced");

  dir_pin_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    disk_changed_n_in |-> dir_disk_changed_out)
    else $error("change pin not passed");

  dir_idle_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!(sel0 && ovr_r[0]) && !(sel1 && ovr_r[1]) && !disk_changed_n_in) |-> !dir_disk_changed_out)
    else $error("change bit set without cause");

  wp_force1_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (ovr_r[2] && sel1) |-> !fdc_write_protect_n_out)
    else $error("wp not forced on drive1");

  wp_pp_pin_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    !pp_write_protect_n_in |-> !fdc_write_protect_n_out)
    else $error("parallel wp pin not passed");

  // game select decode
  game_off_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!pin_function_register_in && gmode == CFGBK_GAME_OFF) |-> !game_chip_select_out)
    else $error("game select while disabled");

  game_full_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (!pin_function_register_in && gmode == CFGBK_GAME_ALL && hi_match && !chip_select_n_in && !io_addr_in[10])
    |-> game_chip_select_out) else $error("game select missed");

  pg_route_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    pin_function_register_in |-> game_chip_select_out == power_good_input_in)
    else $error("pin function not honoured");

  // drive type mapping
  type_pick_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    sel1 |-> {tb0, tb1} == {dtype_r[3], dtype_r[2]})
    else $error("wrong drive type picked");

  dens_inv_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    ({tb0, tb1} == 2'b10) |-> drive_density_out0_out == !fdc_in.density_select)
    else $error("density not inverted");

  // read path in configuration state
  read_path_a: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in)
    (cfg_state_in && cfg_rd_in && config_index_reg_in == `CFGBK_IDX_GAME_BASE) |-> cfg_rdata_out == game_r)
    else $error("game base read wrong");

endmodule // cfgbk_regs
`default_nettype wire

// file: tb/cfgbk_drive_model.sv
// floppy drive model seen across the controller's drive pins
// assumes selects arrive active low in the controller struct
`timescale 1ns/10ps
`default_nettype none
module cfgbk_drive_model
  import cfgbk_pkg::*;
(
  input  wire cfgbk_fdc_type fdc_in,              // controller drive signals
  input  wire logic          media_chg_in,        // media was swapped
  input  wire logic          locked_in,           // write tab set
  output logic               disk_changed_n_out,  // change line
  output logic               write_protect_n_out  // wp line, pulled up
);
  wire logic sel_w;
  // a deselected drive releases its lines to their pull levels, not the last value
  assign sel_w               = ~fdc_in.drive_select0_n | ~fdc_in.drive_select1_n;
  assign disk_changed_n_out  = sel_w & media_chg_in;
  assign write_protect_n_out = ~(sel_w & locked_in);
endmodule // cfgbk_drive_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the configuration bank slice
// assumes inputs move on the falling edge, outputs settle before the rise
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cfgbk_pkg::*;
  logic          clk, rst, strap, cst, wr, rd, rate_wr, s1_wr, s2_wr;
  logic          dchg_n, wp_n, dir, wpo, cs_n, pinfn, pg, gcs, dd0, dd1;
  logic          media, lock, ppwp;
  logic [7:0]    idx, wd, rdata, rwd;
  logic [10:0]   pbase;
  logic [15:0]   addr;
  cfgbk_fdc_type fdc;
  int            miscompares = 0;
  int            compares = 0;
  int            cycles = 0;
  logic [3:0]    nib [5] = '{4'h0, 4'h1, 4'h7, 4'h8, 4'hf};

  cfgbk_regs i_cfgbk_regs (
    .clk_sys_in(clk), .sys_rst_in(rst), .base_strap_pin_in(strap),
    .cfg_state_in(cst), .config_index_reg_in(idx), .cfg_wr_in(wr),
    .cfg_rd_in(rd), .cfg_wdata_in(wd), .cfg_rdata_out(rdata),
    .cfg_port_base_out(pbase), .rate_wr_in(rate_wr), .ser1_fcr_wr_in(s1_wr),
    .ser2_fcr_wr_in(s2_wr), .run_wdata_in(rwd), .fdc_in(fdc),
    .disk_changed_n_in(dchg_n), .write_protect_n_in(wp_n),
    .pp_write_protect_n_in(ppwp), .dir_disk_changed_out(dir),
    .fdc_write_protect_n_out(wpo), .io_addr_in(addr), .chip_select_n_in(cs_n),
    .pin_function_register_in(pinfn), .power_good_input_in(pg),
    .game_chip_select_out(gcs), .drive_density_out0_out(dd0),
    .drive_density_out1_out(dd1));
  cfgbk_drive_model i_cfgbk_drive_model (
    .fdc_in(fdc), .media_chg_in(media), .locked_in(lock),
    .disk_changed_n_out(dchg_n), .write_protect_n_out(wp_n));

  always #20 clk = ~clk;
  // cut a hang short; the sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle write strobe, then a gap cycle
  task automatic wreg(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk);
    {idx, wd, wr} = {i, d, 1'b1};
    @(negedge clk);
    wr = 1'b0;
  endtask
  // index and read enable stand through the sampling edge, read enable dropped on the next fall
  task automatic rreg(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk);
    {idx, rd} = {i, 1'b1};
    @(posedge clk);
    chk(rdata, e);
    @(negedge clk);
    rd = 1'b0;
  endtask
  task automatic shw(input int k, input logic [7:0] d);
    @(negedge clk);
    rwd = d;
    {s2_wr, s1_wr, rate_wr} = 3'b001 << k;
    @(negedge clk);
    {s2_wr, s1_wr, rate_wr} = 3'b000;
  endtask
  task automatic drv(input logic [5:0] f);
    @(negedge clk);
    fdc = f;
    #5;
  endtask
  task automatic gck(input logic [15:0] a, input logic e);
    @(negedge clk);
    addr = a;
    #5 chk(gcs, e);
  endtask
  task automatic do_reset(input logic s, input int n);
    @(negedge clk);
    {strap, rst} = {s, 1'b1};
    repeat (n) @(negedge clk);
    rst = 1'b0;
  endtask
  // f is {density, rate0, rate1}
  function automatic logic [1:0] tmap(input logic [1:0] t, input logic [2:0] f);
    case (t)
      2'd0: return {f[2], f[1]};
      2'd1: return {f[0], f[1]};
      2'd2: return {~f[2], f[1]};
      default: return {f[1], f[0]};
    endcase
  endfunction

  initial begin
    {clk, rst, strap, cst, wr, rd, rate_wr, s1_wr, s2_wr} = 9'b011100000;
    {cs_n, pinfn, pg, media, lock, ppwp} = 6'b100001;
    {idx, wd, rwd, addr} = '0;
    fdc = 6'b111000;
    do_reset(1'b1, 12);
    rreg(8'h12, 8'h70);
    rreg(8'h13, 8'h03);
    chk(pbase, 11'h370);
    rreg(8'h17, 8'h03);
    rreg(8'h1e, 8'h80);
    rreg(8'h1f, 8'h00);
    for (int i = 8'h14; i < 8'h17; i++) rreg(i[7:0], 8'h00);
    // reserved indices swallow writes
    for (int i = 8'h18; i < 8'h1e; i++) begin
      wreg(i[7:0], 8'hff);
      rreg(i[7:0], 8'h00);
    end
    // low byte first; the decode must not move until the high write
    wreg(8'h12, 8'h5b);
    rreg(8'h12, 8'h5a);
    chk(pbase, 11'h370);
    wreg(8'h13, 8'hfe);
    rreg(8'h13, 8'h06);
    chk(pbase, 11'h65a);
    do_reset(1'b0, 2);
    chk(pbase, 11'h3f0);
    rreg(8'h12, 8'hf0);
    // outside configuration state nothing is reached
    cst = 1'b0;
    wreg(8'h1e, 8'h55);
    rreg(8'h1e, 8'h00);
    cst = 1'b1;
    rreg(8'h1e, 8'h80);
    shw(0, 8'ha5);
    shw(1, 8'h3c);
    shw(2, 8'hc3);
    wreg(8'h14, 8'hff);
    rreg(8'h14, 8'ha5);
    rreg(8'h15, 8'h3c);
    rreg(8'h16, 8'hc3);
    // overrides: disk change bits set-only, cleared by step with select; wp bit follows writes
    wreg(8'h17, 8'h00);
    rreg(8'h17, 8'h03);
    drv(6'b101000);
    chk(dir, 1'b1);
    drv(6'b010000);
    drv(6'b110000);
    chk(dir, 1'b0);
    rreg(8'h17, 8'h01);
    media = 1'b1;
    #1 chk(dir, 1'b1);
    media = 1'b0;
    drv(6'b001000);
    drv(6'b101000);
    chk(dir, 1'b0);
    wreg(8'h17, 8'h06);
    rreg(8'h17, 8'h06);
    chk(wpo, 1'b0);
    drv(6'b111000);
    chk(wpo, 1'b1);
    wreg(8'h17, 8'h00);
    rreg(8'h17, 8'h02);
    lock = 1'b1;
    drv(6'b110000);
    chk(wpo, 1'b0);
    // parallel-port write protect pin reaches the controller too
    @(negedge clk);
    {lock, ppwp} = 2'b00;
    #5 chk(wpo, 1'b0);
    // game decode at base 200h over every mode
    @(negedge clk);
    {ppwp, cs_n} = 2'b10;
    for (int m = 0; m < 4; m++) begin
      wreg(8'h1e, {6'h20, m[1:0]});
      foreach (nib[j]) gck({12'h020, nib[j]}, m == 3 || (m == 2 && nib[j] < 8) || (m == 1 && nib[j] == 1));
    end
    gck(16'h0605, 1'b0);
    gck(16'h0215, 1'b0);
    @(negedge clk);
    cs_n = 1'b1;
    gck(16'h0205, 1'b0);
    @(negedge clk);
    {cs_n, pinfn} = 2'b01;
    gck(16'h0205, 1'b0);
    @(negedge clk);
    pg = 1'b1;
    gck(16'h0215, 1'b1);
    // every type against every density and rate bit combination, drive 0 selected
    for (int t = 0; t < 4; t++) begin
      wreg(8'h1f, {6'h03, t[1:0]});
      for (int f = 0; f < 8; f++) begin
        drv({3'b101, f[2:0]});
        chk({dd0, dd1}, tmap(t[1:0], f[2:0]));
      end
    end
    wreg(8'h1f, 8'h0c);
    drv(6'b110010);
    chk({dd0, dd1}, 2'b10);
    rreg(8'h1f, 8'h0c);
    test_done();
  end
endmodule // testbench
`default_nettype wire
